// >>> logic/bgpi_consts.svh
// Constants of the bar graph plot interpreter: command codes, grid sizes, FIFO shape.
// Assumes a command stream of eight-bit words.
`ifndef BGPI_CONSTS_SVH
`define BGPI_CONSTS_SVH
`define BGPI_DATA_W     8
`define BGPI_FIFO_DEPTH 32
`define BGPI_CODE_PLOT  8'h02
`define BGPI_SUB_NONE   8'h00
`define BGPI_CODE_MIN   8'hf0
`define BGPI_CODE_VINC  8'hf3
`define BGPI_CODE_VEND  8'hf4
`define BGPI_CODE_VCOL  8'hf5
`define BGPI_CODE_VSTRT 8'hf6
`define BGPI_CODE_HINC  8'hf7
`define BGPI_CODE_HEND  8'hf8
`define BGPI_CODE_HROW  8'hf9
`define BGPI_CODE_HSTRT 8'hfa
`define BGPI_CODE_XPNT  8'hfd
`define BGPI_CODE_CHAR  8'hfe
`define BGPI_CODE_ESC   8'hff
`define BGPI_GRID_W     8'ha0
`define BGPI_GRID_H     8'h64
`define BGPI_GRID_H48   8'hc0
`define BGPI_INC_POS    2'h2
`define BGPI_INC_NEG    2'h1
`endif

// >>> logic/bgpi_pkg.sv
// Types shared by the bar graph plot interpreter files.
// Assumes nothing of its surroundings.
package bgpi_pkg;
  typedef enum logic [1:0] {
    ST_OFF,
    ST_PLOT,
    ST_WAIT,
    ST_INC2
  } bgpi_state_t;
endpackage

// >>> logic/bgpi_stream_if.sv
// Valid/ready word stream between the interpreter and its FIFO.
// Assumes one clock shared by both ends.
`timescale 1ns/1ns
`default_nettype none
interface bgpi_stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface // bgpi_stream_if
`default_nettype wire

// >>> logic/bgpi_fifo.sv
// Word FIFO with a registered output stage and a registered ready.
// Assumes a single clock and the asynchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module bgpi_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input wire logic      clk,
  input wire logic      sys_rst,
  bgpi_stream_if.snk    wr,
  bgpi_stream_if.src    rd
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] DEPTH = (AW+1)'(D);

  logic [W-1:0]  mem [D];
  logic [AW:0]   count;
  logic [AW-1:0] wPtr;
  logic [AW-1:0] rPtr;

  wire           pushFire = wr.valid && wr.ready;
  wire           popMem   = (count != '0) && (!rd.valid || rd.ready);
  wire [AW:0]    next_count = count + {{AW{1'b0}}, pushFire} - {{AW{1'b0}}, popMem};

  // Storage has no reset so that it can map onto plain RAM.
  always_ff @(posedge clk) begin
    if (pushFire) begin
      mem[wPtr] <= wr.data;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count    <= '0;
      wPtr     <= '0;
      rPtr     <= '0;
      rd.valid <= 1'b0;
      rd.data  <= '0;
      wr.ready <= 1'b0;
    end else begin
      count    <= next_count;
      wPtr     <= pushFire ? AW'(wPtr + 1'b1) : wPtr;
      rPtr     <= popMem ? AW'(rPtr + 1'b1) : rPtr;
      rd.valid <= popMem ? 1'b1 : (rd.ready ? 1'b0 : rd.valid);
      rd.data  <= popMem ? mem[rPtr] : rd.data;
      wr.ready <= next_count < DEPTH;
    end
  end
endmodule // bgpi_fifo
`default_nettype wire

// >>> logic/bgpi_interp.sv
// Bar graph plot interpreter: takes the plot command stream and issues bar draw requests.
// Assumes a renderer that accepts one bar per drawValid/drawReady handshake.
`timescale 1ns/1ns
`default_nettype none
`include "bgpi_consts.svh"

// What this block does
// R1: In plot mode, code 250 selects horizontal bar start-column entry.
// R2: Bar submodes are reachable from every plot submode except character plot, 254.
// R3: Start column 0..159 kept; larger values lose 160 first.
// R4: After the start column, move to row entry, code 249.
// R5: After the row, move to end-column entry, code 248.
// R6: Row 0..99 (0..191 in 48-line); larger values lose 100 (192).
// R7: End column 0..159 kept; larger values lose 160 first.
// R8: The end column draws a bar from start to end on the row.
// R9: After a bar, return to row entry, code 249.
// R10: The start column is kept and reused by later row and end pairs.
// R11: Codes 240..254 switch submode; 255 leaves plot mode.
// R12: Row and end-column entry also open directly by codes 249 and 248.
// R13: Code 247 opens incremental bars; each word with a nonzero low half moves two bars.
// R14: Incremental words use the point plot increment field layout.
// R15: Code 246 opens vertical start-row entry, 0..99 or 0..191.
// R16: Vertical start row above range loses 100 (192) before storing.
// R17: Vertical bars sequence like horizontal ones with axes swapped.
// R18: Coordinates count from the lower left block.
// R19: Host may send 251 between row and end pairs; it selects submode 251, so 249 must be sent again before the next row.
// R20: Every code and coordinate is one eight-bit word.
// R21: Incremental words are 0..239; 240..255 are codes.
// R22: Field 10 is plus, 01 minus, else still; zero low half skips drawing.
// R23: Grid is 160 by 100 blocks, 160 by 192 in 48-line format.
// R24: After reset plot mode is off and no stored coordinate is valid.
module bgpi_interp
  import bgpi_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] hostData,
  input  wire logic       hostValid,
  output logic            hostReady,
  input  wire logic       lines48,
  input  wire logic       drawReady,
  output logic            drawValid,
  output logic            drawVertical,
  output logic [7:0]      drawFixed,
  output logic [7:0]      drawFrom,
  output logic [7:0]      drawTo,
  output logic            plotActive,
  output logic [7:0]      plotSubmode
);

  bgpi_state_t state;
  bgpi_state_t next_state;
  logic [7:0]  startVal;
  logic [7:0]  posVal;
  logic [7:0]  curMaj;
  logic [3:0]  incLow;
  logic        incPend;
  logic        startOk;
  logic        posOk;
  logic [7:0]  startVer;
  logic        startVerOk;
  logic [7:0]  next_sub;
  logic        next_plot;
  logic [7:0]  next_start;
  logic [7:0]  next_pos;
  logic [7:0]  next_maj;
  logic [3:0]  next_incLow;
  logic        next_incPend;
  logic        next_startOk;
  logic        next_posOk;
  logic [7:0]  next_startVer;
  logic        next_startVerOk;
  logic        next_drawValid;
  logic        next_drawVertical;
  logic [7:0]  next_drawFixed;
  logic [7:0]  next_drawFrom;
  logic [7:0]  next_drawTo;

  bgpi_stream_if #(.W(`BGPI_DATA_W)) hostSide ();
  bgpi_stream_if #(.W(`BGPI_DATA_W)) popSide ();

  // Each stream word is one code or one coordinate, never split. [R20]
  assign hostSide.data  = hostData;
  assign hostSide.valid = hostValid;
  assign hostReady      = hostSide.ready;

  bgpi_fifo #(.W(`BGPI_DATA_W), .D(`BGPI_FIFO_DEPTH)) cmdFifo (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr      (hostSide.snk),
    .rd      (popSide.src)
  );

  // The interpreter stalls the FIFO while a bar waits for the renderer, which is
  // how long bars push back on the host. [R19]
  wire       popReady = (state == ST_OFF) || (state == ST_PLOT);
  assign popSide.ready = popReady;
  wire [7:0] popData  = popSide.data;
  wire       popFire  = popSide.valid && popReady;

  wire isEsc    = popData == `BGPI_CODE_ESC;
  wire isCode   = popData >= `BGPI_CODE_MIN; // [R21]
  wire inChar   = plotSubmode == `BGPI_CODE_CHAR;
  wire barStart = plotSubmode == `BGPI_CODE_HSTRT || plotSubmode == `BGPI_CODE_VSTRT;
  wire barPos   = plotSubmode == `BGPI_CODE_HROW || plotSubmode == `BGPI_CODE_VCOL;
  wire barEnd   = plotSubmode == `BGPI_CODE_HEND || plotSubmode == `BGPI_CODE_VEND;
  wire barInc   = plotSubmode == `BGPI_CODE_HINC || plotSubmode == `BGPI_CODE_VINC;
  wire vert     = plotSubmode == `BGPI_CODE_VSTRT || plotSubmode == `BGPI_CODE_VCOL
               || plotSubmode == `BGPI_CODE_VEND || plotSubmode == `BGPI_CODE_VINC; // [R17]
  wire [7:0] posCode  = vert ? `BGPI_CODE_VCOL : `BGPI_CODE_HROW;
  wire [7:0] endCode  = vert ? `BGPI_CODE_VEND : `BGPI_CODE_HEND;

  // Rows count up from the bottom edge, columns from the left edge. [R18]
  wire [7:0] rowLim = lines48 ? `BGPI_GRID_H48 : `BGPI_GRID_H; // [R23]
  wire [7:0] majLim = vert ? rowLim : `BGPI_GRID_W;
  wire [7:0] posLim = vert ? `BGPI_GRID_W : rowLim;
  // A single subtraction is applied, as for the other plot coordinates. [R3] [R6] [R7] [R16]
  wire [7:0] wrapMaj = (popData >= majLim) ? 8'(popData - majLim) : popData;
  wire [7:0] wrapPos = (popData >= posLim) ? 8'(popData - posLim) : popData;

  // Increment half: high pair moves X, low pair moves Y. [R14]
  wire [3:0] incHalf  = (state == ST_INC2) ? incLow : popData[7:4];
  wire [1:0] majField = vert ? incHalf[1:0] : incHalf[3:2];
  wire [1:0] posField = vert ? incHalf[3:2] : incHalf[1:0];
  wire [7:0] incMaj   = stepCoord(curMaj, majField, majLim);
  wire [7:0] incPos   = stepCoord(posVal, posField, posLim);
  // Each axis keeps its own start, so a vertical bar never disturbs the held start column. [R10] [R17]
  wire [7:0] barFrom  = vert ? startVer : startVal;
  wire       barOk    = vert ? startVerOk : startOk;
  wire       bothOk   = barOk && posOk;

  // Moves wrap around the grid edge rather than sticking at it.
  function automatic logic [7:0] stepCoord(input logic [7:0] v, input logic [1:0] f, input logic [7:0] lim);
    logic [7:0] r;
    r = v;
    if (f == `BGPI_INC_POS) begin // [R22]
      r = (v == 8'(lim - 8'h01)) ? 8'h00 : 8'(v + 8'h01);
    end else if (f == `BGPI_INC_NEG) begin
      r = (v == 8'h00) ? 8'(lim - 8'h01) : 8'(v - 8'h01);
    end
    return r;
  endfunction

  always_comb begin
    next_state        = state;
    next_sub          = plotSubmode;
    next_plot         = plotActive;
    next_start        = startVal;
    next_pos          = posVal;
    next_maj          = curMaj;
    next_incLow       = incLow;
    next_incPend      = incPend;
    next_startOk      = startOk;
    next_posOk        = posOk;
    next_startVer     = startVer;
    next_startVerOk   = startVerOk;
    next_drawValid    = drawValid;
    next_drawVertical = drawVertical;
    next_drawFixed    = drawFixed;
    next_drawFrom     = drawFrom;
    next_drawTo       = drawTo;
    case (state)
      ST_OFF: begin
        if (popFire && popData == `BGPI_CODE_PLOT) begin
          next_plot  = 1'b1;
          next_sub   = `BGPI_CODE_XPNT;
          next_state = ST_PLOT;
        end
      end
      ST_PLOT: begin
        if (popFire) begin
          if (isEsc) begin // [R11]
            next_plot  = 1'b0;
            next_sub   = `BGPI_SUB_NONE;
            next_state = ST_OFF;
          end else if (inChar) begin
            // Character plot swallows every word but the escape. [R2]
            next_sub = plotSubmode;
          end else if (isCode) begin // [R1] [R2] [R11] [R12] [R13] [R15]
            next_sub = popData;
          end else if (barStart) begin // [R3] [R16]
            if (vert) begin
              next_startVer   = wrapMaj;
              next_startVerOk = 1'b1;
            end else begin
              next_start   = wrapMaj;
              next_startOk = 1'b1;
            end
            next_sub     = posCode; // [R4]
          end else if (barPos) begin // [R6]
            next_pos   = wrapPos;
            next_posOk = 1'b1;
            next_sub   = endCode; // [R5]
          end else if (barEnd) begin // [R7]
            next_maj = wrapMaj;
            next_sub = posCode; // [R9]
            if (bothOk) begin // [R8] [R10]
              next_drawValid    = 1'b1;
              next_drawVertical = vert;
              next_drawFixed    = posVal;
              next_drawFrom     = barFrom;
              next_drawTo       = wrapMaj;
              next_state        = ST_WAIT;
            end
          end else if (barInc) begin // [R13]
            next_maj    = incMaj;
            next_pos    = incPos;
            next_incLow = popData[3:0];
            if (popData[3:0] == 4'h0) begin
              // Zero low half: move only, so a gap can be stepped over. [R22]
              next_incPend = 1'b0;
            end else if (bothOk) begin
              next_incPend      = 1'b1;
              next_drawValid    = 1'b1;
              next_drawVertical = vert;
              next_drawFixed    = incPos;
              next_drawFrom     = barFrom;
              next_drawTo       = incMaj;
              next_state        = ST_WAIT;
            end else begin
              next_state = ST_INC2;
            end
          end
        end
      end
      ST_WAIT: begin
        if (drawReady) begin
          next_drawValid = 1'b0;
          next_incPend   = 1'b0;
          next_state     = incPend ? ST_INC2 : ST_PLOT;
        end
      end
      ST_INC2: begin
        next_maj   = incMaj;
        next_pos   = incPos;
        next_state = ST_PLOT;
        if (bothOk) begin
          next_drawValid    = 1'b1;
          next_drawVertical = vert;
          next_drawFixed    = incPos;
          next_drawFrom     = barFrom;
          next_drawTo       = incMaj;
          next_state        = ST_WAIT;
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin // [R24]
      state       <= ST_OFF;
      plotActive  <= 1'b0;
      plotSubmode <= `BGPI_SUB_NONE;
      startOk     <= 1'b0;
      startVerOk  <= 1'b0;
      posOk       <= 1'b0;
      incPend     <= 1'b0;
    end else begin
      state       <= next_state;
      plotActive  <= next_plot;
      plotSubmode <= next_sub;
      startOk     <= next_startOk;
      startVerOk  <= next_startVerOk;
      posOk       <= next_posOk;
      incPend     <= next_incPend;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      startVal <= 8'h00;
      startVer <= 8'h00;
      posVal   <= 8'h00;
      curMaj   <= 8'h00;
      incLow   <= 4'h0;
    end else begin
      startVal <= next_start;
      startVer <= next_startVer;
      posVal   <= next_pos;
      curMaj   <= next_maj;
      incLow   <= next_incLow;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      drawValid    <= 1'b0;
      drawVertical <= 1'b0;
      drawFixed    <= 8'h00;
      drawFrom     <= 8'h00;
      drawTo       <= 8'h00;
    end else begin
      drawValid    <= next_drawValid;
      drawVertical <= next_drawVertical;
      drawFixed    <= next_drawFixed;
      drawFrom     <= next_drawFrom;
      drawTo       <= next_drawTo;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  wire dataWord = popFire && !isCode;

  AST_ENTER_START: assert property ( // [R1]
    popFire && state == ST_PLOT && !inChar && popData == `BGPI_CODE_HSTRT |=> plotSubmode == `BGPI_CODE_HSTRT)
    else $error("Code 250 did not select start-column entry.");
  AST_CHAR_LOCK: assert property ( // [R2]
    popFire && inChar && !isEsc |=> plotSubmode == `BGPI_CODE_CHAR)
    else $error("Character plot left by a code other than escape.");
  AST_START_WRAP: assert property ( // [R3]
    dataWord && plotSubmode == `BGPI_CODE_HSTRT
    |=> startVal == (($past(popData) >= `BGPI_GRID_W) ? 8'($past(popData) - `BGPI_GRID_W) : $past(popData)))
    else $error("Start column stored with the wrong value.");
  AST_START_TO_ROW: assert property ( // [R4]
    dataWord && plotSubmode == `BGPI_CODE_HSTRT |=> plotSubmode == `BGPI_CODE_HROW && startOk)
    else $error("Start column did not lead to row entry.");
  AST_ROW_TO_END: assert property ( // [R5]
    dataWord && plotSubmode == `BGPI_CODE_HROW |=> plotSubmode == `BGPI_CODE_HEND)
    else $error("Row did not lead to end-column entry.");
  AST_ROW_WRAP: assert property ( // [R6]
    dataWord && plotSubmode == `BGPI_CODE_HROW && !lines48
    |=> posVal == (($past(popData) >= `BGPI_GRID_H) ? 8'($past(popData) - `BGPI_GRID_H) : $past(popData)))
    else $error("Row stored with the wrong value.");
  AST_END_DRAWS: assert property ( // [R8]
    dataWord && plotSubmode == `BGPI_CODE_HEND && startOk && posOk
    |=> drawValid && !drawVertical && drawFrom == $past(startVal) && drawFixed == $past(posVal))
    else $error("End column did not request the expected bar.");
  AST_END_TO_ROW: assert property ( // [R9]
    dataWord && plotSubmode == `BGPI_CODE_HEND |=> plotSubmode == `BGPI_CODE_HROW)
    else $error("Bar end did not return to row entry.");
  AST_START_HELD: assert property ( // [R10]
    popFire && (barPos || barEnd) |=> $stable(startVal) && $stable(startVer))
    else $error("Start column changed outside start entry.");
  AST_ESCAPE: assert property ( // [R11]
    popFire && state == ST_PLOT && isEsc |=> !plotActive && plotSubmode == `BGPI_SUB_NONE)
    else $error("Escape did not leave plot mode.");
  AST_SUBMODE: assert property ( // [R12]
    popFire && state == ST_PLOT && !inChar && isCode && !isEsc |=> plotSubmode == $past(popData))
    else $error("Submode code not taken.");
  AST_VSTART_WRAP: assert property ( // [R16]
    dataWord && plotSubmode == `BGPI_CODE_VSTRT && lines48
    |=> startVer == (($past(popData) >= `BGPI_GRID_H48) ? 8'($past(popData) - `BGPI_GRID_H48) : $past(popData)))
    else $error("Vertical start row stored with the wrong value.");
  AST_INC_SKIP: assert property ( // [R22]
    dataWord && barInc && popData[3:0] == 4'h0 |=> !drawValid && state == ST_PLOT)
    else $error("Zero low half still drew a bar.");
  AST_DRAW_HOLD: assert property ( // [R8]
    drawValid && !drawReady |=> drawValid && $stable(drawTo) && $stable(drawFrom) && $stable(drawFixed))
    else $error("Bar request dropped before it was taken.");
  AST_GRID: assert property ( // [R23]
    drawValid && !drawVertical |-> drawTo < `BGPI_GRID_W && drawFrom < `BGPI_GRID_W)
    else $error("Horizontal bar leaves the grid.");

  COV_HBAR: cover property (drawValid && drawReady && !drawVertical);
  COV_VBAR: cover property (drawValid && drawReady && drawVertical);
  COV_INC_TWO: cover property (state == ST_INC2 && bothOk);
  COV_ESCAPE: cover property (popFire && state == ST_PLOT && isEsc);
endmodule // bgpi_interp
`default_nettype wire

// >>> verification/bgpi_render_model.sv
// Renderer model standing on the far side of the draw port.
// Assumes the interpreter holds each request and its fields until drawReady is sampled high.
`timescale 1ns/1ns
`default_nettype none
module bgpi_render_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        drawValid,
  input  wire logic        drawVertical,
  input  wire logic [7:0]  drawFixed,
  input  wire logic [7:0]  drawFrom,
  input  wire logic [7:0]  drawTo,
  input  wire logic        stall,
  input  wire logic [7:0]  lag,
  output logic             drawReady,
  output logic [24:0]      lastBar,
  output logic [15:0]      barCount
);
  logic [7:0] waitCnt;

  // A long bar keeps the real renderer busy longer, so the lag and the stall are set per scenario.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      drawReady <= 1'b0;
      waitCnt   <= 8'h00;
      lastBar   <= 25'h0000000;
      barCount  <= 16'h0000;
    end else if (drawReady) begin
      drawReady <= 1'b0;
      waitCnt   <= 8'h00;
      lastBar   <= {drawVertical, drawFixed, drawFrom, drawTo};
      barCount  <= barCount + 16'h0001;
    end else if (drawValid && !stall) begin
      if (waitCnt >= lag) begin
        drawReady <= 1'b1;
      end else begin
        waitCnt <= waitCnt + 8'h01;
      end
    end
  end
endmodule // bgpi_render_model
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench of the bar graph plot interpreter.
// Assumes the renderer model beside it and a 10 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        clk;
  logic        sys_rst;
  logic [7:0]  hostData;
  logic        hostValid;
  logic        hostReady;
  logic        lines48;
  logic        drawReady;
  logic        drawValid;
  logic        drawVertical;
  logic [7:0]  drawFixed;
  logic [7:0]  drawFrom;
  logic [7:0]  drawTo;
  logic        plotActive;
  logic [7:0]  plotSubmode;
  logic        stall;
  logic [7:0]  lag;
  logic [24:0] lastBar;
  logic [15:0] barCount;
  int          errTotal;
  int          checked;
  int          barsSeen;

  bgpi_interp bgpi_interp_inst (.clk(clk), .sys_rst(sys_rst), .hostData(hostData), .hostValid(hostValid),
    .hostReady(hostReady), .lines48(lines48), .drawReady(drawReady), .drawValid(drawValid),
    .drawVertical(drawVertical), .drawFixed(drawFixed), .drawFrom(drawFrom), .drawTo(drawTo),
    .plotActive(plotActive), .plotSubmode(plotSubmode));

  bgpi_render_model bgpi_render_model_inst (.clk(clk), .sys_rst(sys_rst), .drawValid(drawValid),
    .drawVertical(drawVertical), .drawFixed(drawFixed), .drawFrom(drawFrom), .drawTo(drawTo),
    .stall(stall), .lag(lag), .drawReady(drawReady), .lastBar(lastBar), .barCount(barCount));

  always #50 clk = ~clk;

  task automatic endSim();
    if (errTotal == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic fail();
    errTotal++;
    endSim();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errTotal++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Entered just after a rising edge; the word is held until an edge that samples hostReady high.
  task automatic send(input logic [7:0] b);
    logic r;
    int   i;
    hostData  <= b;
    hostValid <= 1'b1;
    i = 0;
    do begin
      @(negedge clk);
      r = hostReady;
      @(posedge clk);
      i++;
    end while (r !== 1'b1 && i < 500);
    if (r !== 1'b1) fail();
    // One idle edge, so that a following call never reassigns hostValid in this time step.
    hostValid <= 1'b0;
    @(posedge clk);
  endtask

  task automatic waitSub(input logic [7:0] exp);
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (plotSubmode !== exp && i < 40);
    chk(plotSubmode, exp);
    if (plotSubmode !== exp) endSim();
    @(posedge clk);
  endtask

  task automatic expBar(input logic v, input logic [7:0] f, input logic [7:0] a, input logic [7:0] b);
    int i;
    for (i = 0; i < 300 && barCount == barsSeen; i++) @(negedge clk);
    if (barCount == barsSeen) fail();
    barsSeen++;
    chk(lastBar, {v, f, a, b});
    @(posedge clk);
  endtask

  task automatic tReset();
    @(negedge clk);
    chk({plotActive, plotSubmode, drawValid}, 10'h000);
    @(posedge clk);
    send(8'hfa);
    send(8'h02);
    waitSub(8'hfd);
    send(8'hf8);
    send(8'h32);
    repeat (20) @(posedge clk);
    chk(barCount, 16'h0000);
  endtask

  task automatic tHoriz();
    send(8'hfa);
    send(8'haa);
    waitSub(8'hf9);
    send(8'h14);
    waitSub(8'hf8);
    send(8'h1e);
    expBar(1'h0, 8'h14, 8'h0a, 8'h1e);
    waitSub(8'hf9);
    send(8'h78);
    send(8'ha5);
    expBar(1'h0, 8'h14, 8'h0a, 8'h05);
    send(8'h63);
    send(8'h9f);
    expBar(1'h0, 8'h63, 8'h0a, 8'h9f);
  endtask

  task automatic tDirect();
    send(8'hf8);
    send(8'h32);
    expBar(1'h0, 8'h63, 8'h0a, 8'h32);
    send(8'hfb);
    send(8'hf9);
    send(8'h07);
    send(8'h09);
    expBar(1'h0, 8'h07, 8'h0a, 8'h09);
  endtask

  task automatic tInc();
    lag <= 8'h09;
    send(8'hf9);
    send(8'h14);
    send(8'h32);
    expBar(1'h0, 8'h14, 8'h0a, 8'h32);
    send(8'hf7);
    send(8'h8a);
    expBar(1'h0, 8'h14, 8'h0a, 8'h33);
    expBar(1'h0, 8'h15, 8'h0a, 8'h34);
    send(8'h40);
    send(8'h8a);
    expBar(1'h0, 8'h15, 8'h0a, 8'h34);
    expBar(1'h0, 8'h16, 8'h0a, 8'h35);
    send(8'h96);
    expBar(1'h0, 8'h15, 8'h0a, 8'h36);
    expBar(1'h0, 8'h16, 8'h0a, 8'h35);
    send(8'hcc);
    expBar(1'h0, 8'h16, 8'h0a, 8'h35);
    expBar(1'h0, 8'h16, 8'h0a, 8'h35);
    waitSub(8'hf7);
    lag <= 8'h00;
  endtask

  task automatic tVert();
    send(8'hf6);
    send(8'h69);
    waitSub(8'hf5);
    send(8'ha0);
    waitSub(8'hf4);
    send(8'h6e);
    expBar(1'h1, 8'h00, 8'h05, 8'h0a);
    waitSub(8'hf5);
    lines48 <= 1'b1;
    send(8'hf9);
    send(8'h96);
    send(8'h0c);
    expBar(1'h0, 8'h96, 8'h0a, 8'h0c);
    send(8'hc8);
    send(8'h0d);
    expBar(1'h0, 8'h08, 8'h0a, 8'h0d);
    send(8'hf6);
    send(8'hc5);
    send(8'h1e);
    send(8'hbf);
    expBar(1'h1, 8'h1e, 8'h05, 8'hbf);
    send(8'hf3);
    send(8'h2a);
    expBar(1'h1, 8'h1e, 8'h05, 8'h00);
    expBar(1'h1, 8'h1f, 8'h05, 8'h01);
    lines48 <= 1'b0;
  endtask

  task automatic tCodes();
    logic [7:0] c;
    for (c = 8'hf0; c != 8'hff; c++) begin
      send(c);
      waitSub(c);
    end
    send(8'hfa);
    repeat (20) @(posedge clk);
    chk(plotSubmode, 8'hfe);
    send(8'hff);
    waitSub(8'h00);
    chk(plotActive, 1'b0);
    send(8'h02);
    waitSub(8'hfd);
  endtask

  // The renderer stalls so the interpreter stops draining and the FIFO fills until it refuses.
  task automatic tFill();
    logic r;
    int   n;
    int   i;
    stall <= 1'b1;
    send(8'hf9);
    n = 0;
    hostData  <= 8'h03;
    hostValid <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(negedge clk);
      r = hostReady;
      @(posedge clk);
      if (r === 1'b1) begin
        n++;
        hostData <= n[0] ? 8'h04 : 8'h03;
      end
    end
    hostValid <= 1'b0;
    chk(hostReady, 1'b0);
    chk(drawValid, 1'b1);
    chk(n >= 32 && n < 60, 1'b1);
    stall <= 1'b0;
    n = barsSeen + n / 2;
    for (i = 0; i < 3000 && barCount != n; i++) @(negedge clk);
    chk(barCount, n);
    if (barCount != n) endSim();
    chk(lastBar, {1'h0, 8'h03, 8'h0a, 8'h04});
    barsSeen = n;
  endtask

  initial begin
    clk       = 1'b0;
    sys_rst   = 1'b1;
    hostData  = 8'h00;
    hostValid = 1'b0;
    lines48   = 1'b0;
    stall     = 1'b0;
    lag       = 8'h00;
    errTotal  = 0;
    checked   = 0;
    barsSeen  = 0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    tReset();
    tHoriz();
    tDirect();
    tInc();
    tVert();
    tCodes();
    tFill();
    endSim();
  end
endmodule // tb
`default_nettype wire
